// File: design/apc_regs.v
`timescale 1ns/1ps
`include "apc_regs_map.vh"

// Overview of the block
// Holds the accelerometer pin, routing, self-test and power controls.
// The host reaches every register over the peripheral bus as one aligned word;
// only the low byte carries data and the upper bytes always read as zero.
// Every transfer completes with zero wait states, so the host never stalls.
// Unmapped addresses answer with an error and leave all state untouched.
// The soft-reset command starts a long countdown rather than acting at once,
// so a host that polls straight after the command still sees its old settings.
// The acquisition logic sits on the same clock, so its ready pulse is used
// directly with no synchroniser in front of it.
// Pin outputs and mode outputs are registered, which costs one clock of delay
// after each write but keeps glitches off the pins.
// Limitation: the input-enable bits are only passed through to the pad ring;
// this block does not sample the pins when they act as inputs.

module apc_regs #(
    parameter SOFT_RESET_CYCLES = `APC_SOFT_RESET_CYCLES  // Soft-reset delay in clocks
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        data_ready_evt,
    output reg         acq_enable,
    output reg         selftest_active,
    output reg         selftest_negative,
    output reg         soft_reset_busy,
    output reg         irq_pin_a_out,
    output reg         irq_pin_a_oe,
    output reg         irq_pin_a_in_en,
    output reg         irq_pin_b_out,
    output reg         irq_pin_b_oe,
    output reg         irq_pin_b_in_en
);

    localparam CNT_W = 24;                    // Wide enough for the soft-reset delay
    // The counter width covers the default delay with headroom; a longer
    // delay parameter would need a wider counter as well.
    // Every configuration register is eight bits; reserved pin and routing bits are forced to zero
    // on write, and the code registers keep the whole written byte; reads apply no separate masking.

    // Configuration registers
    reg  [7:0]       pin_a_cfg_r;             // Pin A configuration
    reg  [7:0]       pin_b_cfg_r;             // Pin B configuration
    reg  [7:0]       routing_r;               // Ready-event routing
    reg  [7:0]       selftest_r;              // Self-test code
    reg  [7:0]       pwr_save_r;              // Power-save code
    reg  [7:0]       on_off_r;                // Sensor on/off code
    reg              ready_flag_r;            // Sticky ready status
    reg  [CNT_W-1:0] rst_cnt_r;               // Soft-reset countdown

    // Bus decode
    // A transfer takes effect in its access phase only, when psel and penable
    // stand together; pready is always high, so that is a single cycle.
    // A write also needs the lowest byte strobe, since only that lane is used.
    // The word index drops the two byte-offset bits of the address.
    wire       access   = psel & penable;
    wire       wr_en    = access & pwrite & pstrb[0];
    wire       rd_en    = access & ~pwrite;
    wire [9:0] word_idx = paddr[11:2];
    wire [7:0] wbyte    = pwdata[7:0];

    // Index match helper, used by every register
    // Misaligned addresses never match, so a stray byte access is refused
    // instead of aliasing onto a neighbouring register.
    function hit;
        input [9:0] idx;
        input [7:0] reg_idx;
        begin
            hit = (idx == {2'b00, reg_idx}) && (paddr[1:0] == 2'b00);
        end
    endfunction

    // Delay ends when the countdown reaches one
    // Ending at one rather than zero makes the busy span exactly as many
    // clocks as the parameter says.
    // Only the exact command code starts the sequence; other values are dropped.
    wire soft_reset_fire = soft_reset_busy & (rst_cnt_r == {{(CNT_W-1){1'b0}}, 1'b1});
    wire soft_reset_cmd  = wr_en & hit(word_idx, `APC_IDX_SOFT_RESET) & (wbyte == `APC_SOFT_RESET_CODE);

    // Always ready: zero wait states keep the host simple
    // Read data is prepared in the setup cycle, so no wait state is needed.
    assign pready  = 1'b1;
    // Unmapped offsets answer with an error; reads of them return zero
    assign pslverr = access & ~(hit(word_idx, `APC_IDX_PIN_A_CFG) | hit(word_idx, `APC_IDX_PIN_B_CFG) |
                     hit(word_idx, `APC_IDX_ROUTING) | hit(word_idx, `APC_IDX_SELFTEST) |
                     hit(word_idx, `APC_IDX_PWR_SAVE) | hit(word_idx, `APC_IDX_ON_OFF) |
                     hit(word_idx, `APC_IDX_SOFT_RESET) | hit(word_idx, `APC_IDX_EVENT_STATUS));

    // Register writes and soft-reset restore
    // The restore at the end of the soft-reset delay takes priority over a
    // write in the same cycle, so the host always ends with reset values.
    // Writes during the countdown are still accepted; they are overwritten
    // when the countdown ends.
    // Self-test and power codes are stored whole; unknown codes simply do
    // nothing in the mode decode below.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_a_cfg_r <= `APC_RST_PIN_CFG;
            pin_b_cfg_r <= `APC_RST_PIN_CFG;
            routing_r   <= `APC_RST_ROUTING;
            selftest_r  <= `APC_RST_SELFTEST;
            pwr_save_r  <= `APC_RST_PWR_SAVE;
            on_off_r    <= `APC_RST_ON_OFF;
        end else if (soft_reset_fire) begin
            // Restore all configuration after the delay
            pin_a_cfg_r <= `APC_RST_PIN_CFG;
            pin_b_cfg_r <= `APC_RST_PIN_CFG;
            routing_r   <= `APC_RST_ROUTING;
            selftest_r  <= `APC_RST_SELFTEST;
            pwr_save_r  <= `APC_RST_PWR_SAVE;
            on_off_r    <= `APC_RST_ON_OFF;
        end else if (wr_en) begin
            // Reserved bits of the pin and routing registers masked off on write
            if (hit(word_idx, `APC_IDX_PIN_A_CFG)) begin
                pin_a_cfg_r <= wbyte & `APC_PIN_CFG_MASK;
            end
            if (hit(word_idx, `APC_IDX_PIN_B_CFG)) begin
                pin_b_cfg_r <= wbyte & `APC_PIN_CFG_MASK;
            end
            if (hit(word_idx, `APC_IDX_ROUTING)) begin
                routing_r <= wbyte & `APC_ROUTE_MASK;
            end
            if (hit(word_idx, `APC_IDX_SELFTEST)) begin
                selftest_r <= wbyte;
            end
            if (hit(word_idx, `APC_IDX_PWR_SAVE)) begin
                pwr_save_r <= wbyte;
            end
            if (hit(word_idx, `APC_IDX_ON_OFF)) begin
                on_off_r <= wbyte;
            end
        end
    end

    // Soft-reset countdown; accepted whatever the power mode
    // The countdown runs from the bus clock, not from the acquisition path,
    // so suspend cannot stall it.
    // A repeated command while busy is ignored instead of restarting, which
    // bounds the total delay a misbehaving host can cause.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_reset_busy <= 1'b0;
            rst_cnt_r       <= {CNT_W{1'b0}};
        end else if (soft_reset_cmd && !soft_reset_busy) begin
            // Other codes are simply ignored; a repeat while busy does not restart
            soft_reset_busy <= 1'b1;
            rst_cnt_r       <= SOFT_RESET_CYCLES[CNT_W-1:0];
        end else if (soft_reset_fire) begin
            soft_reset_busy <= 1'b0;
            rst_cnt_r       <= {CNT_W{1'b0}};
        end else if (soft_reset_busy) begin
            rst_cnt_r <= rst_cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // Ready status: event set wins over read clear
    // Letting the set win means an event that lands on the clearing read is
    // not lost; the host sees it on its next read instead.
    // Events are ignored unless acquisition runs, so stale pulses from the
    // sensor path while off or suspended never raise the flag.
    // The end of a soft reset clears the flag together with the registers.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_flag_r <= 1'b0;
        end else if (soft_reset_fire) begin
            ready_flag_r <= 1'b0;
        end else if (data_ready_evt && acq_enable) begin
            ready_flag_r <= 1'b1;
        end else if (rd_en && hit(word_idx, `APC_IDX_EVENT_STATUS)) begin
            ready_flag_r <= 1'b0;
        end
    end

    // Read data, registered at the edge that ends the setup cycle; reserved bits zero
    // The capture happens at the edge that ends the setup cycle, so the data
    // stands through the whole access cycle and is taken at its end.
    // prdata then holds until the next read setup; writes leave it alone.
    // The status flag is captured before the clearing edge, so the host reads
    // the value that the read itself clears.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (hit(word_idx, `APC_IDX_PIN_A_CFG)) begin
                prdata[7:0] <= pin_a_cfg_r;
            end
            if (hit(word_idx, `APC_IDX_PIN_B_CFG)) begin
                prdata[7:0] <= pin_b_cfg_r;
            end
            if (hit(word_idx, `APC_IDX_ROUTING)) begin
                prdata[7:0] <= routing_r;
            end
            if (hit(word_idx, `APC_IDX_SELFTEST)) begin
                prdata[7:0] <= selftest_r;
            end
            if (hit(word_idx, `APC_IDX_PWR_SAVE)) begin
                prdata[7:0] <= pwr_save_r;
            end
            if (hit(word_idx, `APC_IDX_ON_OFF)) begin
                prdata[7:0] <= on_off_r;
            end
            if (hit(word_idx, `APC_IDX_EVENT_STATUS)) begin
                prdata[`APC_STATUS_READY_BIT] <= ready_flag_r;
            end
        end
    end

    // Mode decode and pin drive
    // All outputs are registered one clock after the configuration changes.
    // Acquisition needs the on code, the active code and no soft reset pending;
    // any other combination, including unknown codes, keeps the sensor idle.
    // For open drain the enable is only raised when the pin must be pulled low,
    // and the external pull-up provides the high level.
    // A pin whose output enable is clear neither drives nor shows the event.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acq_enable        <= 1'b0;
            selftest_active   <= 1'b0;
            selftest_negative <= 1'b0;
            irq_pin_a_out     <= 1'b0;
            irq_pin_a_oe      <= 1'b0;
            irq_pin_a_in_en   <= 1'b0;
            irq_pin_b_out     <= 1'b0;
            irq_pin_b_oe      <= 1'b0;
            irq_pin_b_in_en   <= 1'b0;
        end else begin
            // Acquire only when on and active; suspend clears acq_enable
            acq_enable <= (on_off_r == `APC_ACC_ON) && (pwr_save_r == `APC_PWR_ACTIVE) && !soft_reset_busy;
            // Level held for as long as the code stands; no auto-off
            selftest_active   <= (selftest_r == `APC_ST_NEGATIVE) || (selftest_r == `APC_ST_POSITIVE);
            selftest_negative <= (selftest_r == `APC_ST_NEGATIVE);
            irq_pin_a_in_en   <= pin_a_cfg_r[`APC_PIN_IN_BIT];
            irq_pin_b_in_en   <= pin_b_cfg_r[`APC_PIN_IN_BIT];
            // Pin A: mapped, enabled, with polarity and drive type
            if (pin_a_cfg_r[`APC_PIN_OUT_BIT]) begin
                irq_pin_a_out <= (ready_flag_r & routing_r[`APC_ROUTE_A_BIT]) ~^ pin_a_cfg_r[`APC_PIN_LVL_BIT];
                // Open drain only drives the low level
                irq_pin_a_oe  <= ~pin_a_cfg_r[`APC_PIN_OD_BIT] |
                                 ~((ready_flag_r & routing_r[`APC_ROUTE_A_BIT]) ~^ pin_a_cfg_r[`APC_PIN_LVL_BIT]);
            end else begin
                irq_pin_a_out <= 1'b0;
                irq_pin_a_oe  <= 1'b0;
            end
            // Pin B: same scheme
            // Kept as a separate branch so each pin can be traced on its own
            if (pin_b_cfg_r[`APC_PIN_OUT_BIT]) begin
                irq_pin_b_out <= (ready_flag_r & routing_r[`APC_ROUTE_B_BIT]) ~^ pin_b_cfg_r[`APC_PIN_LVL_BIT];
                irq_pin_b_oe  <= ~pin_b_cfg_r[`APC_PIN_OD_BIT] |
                                 ~((ready_flag_r & routing_r[`APC_ROUTE_B_BIT]) ~^ pin_b_cfg_r[`APC_PIN_LVL_BIT]);
            end else begin
                irq_pin_b_out <= 1'b0;
                irq_pin_b_oe  <= 1'b0;
            end
        end
    end

endmodule

// File: design/apc_regs_map.vh
`ifndef APC_REGS_MAP_VH
`define APC_REGS_MAP_VH
// Register word indices (printed offsets not all multiples of four: byte address is index * 4)
`define APC_IDX_PIN_A_CFG      8'h53
`define APC_IDX_PIN_B_CFG      8'h54
`define APC_IDX_ROUTING        8'h58
`define APC_IDX_SELFTEST       8'h6D
`define APC_IDX_PWR_SAVE       8'h7C
`define APC_IDX_ON_OFF         8'h7D
`define APC_IDX_SOFT_RESET     8'h7E
`define APC_IDX_EVENT_STATUS   8'h1D
// Pin configuration fields
`define APC_PIN_IN_BIT         4
`define APC_PIN_OUT_BIT        3
`define APC_PIN_OD_BIT         2
`define APC_PIN_LVL_BIT        1
`define APC_PIN_CFG_MASK       8'h1E
// Routing fields
`define APC_ROUTE_A_BIT        2
`define APC_ROUTE_B_BIT        6
`define APC_ROUTE_MASK         8'h44
// Status field
`define APC_STATUS_READY_BIT   7
// Reset values
`define APC_RST_PIN_CFG        8'h00
`define APC_RST_ROUTING        8'h00
`define APC_RST_SELFTEST       8'h00
`define APC_RST_PWR_SAVE       8'h03
`define APC_RST_ON_OFF         8'h00
// Codes
`define APC_ST_OFF             8'h00
`define APC_ST_POSITIVE        8'h0D
`define APC_ST_NEGATIVE        8'h09
`define APC_PWR_SUSPEND        8'h03
`define APC_PWR_ACTIVE         8'h00
`define APC_ACC_ON             8'h04
`define APC_ACC_OFF            8'h00
`define APC_SOFT_RESET_CODE    8'hB6
// Soft-reset delay: 1 ms at 200 MHz
`define APC_SOFT_RESET_NS      1000000
`define APC_CLK_PERIOD_NS      5
`define APC_SOFT_RESET_CYCLES  (`APC_SOFT_RESET_NS / `APC_CLK_PERIOD_NS)
`endif

// File: sim/apc_regs_assertions.sv
`timescale 1ns/1ps
// Pin-level watcher for the register block
module apc_regs_assertions (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        acq_enable,
    input wire        selftest_active,
    input wire        selftest_negative,
    input wire        soft_reset_busy,
    input wire        irq_pin_a_in_en
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed read access, completed write to one address
    sequence rd_s; psel && penable && pready && !pwrite; endsequence
    sequence wr_s(a); psel && penable && pwrite && paddr == a; endsequence
    a_ready_const: assert property (pready)
        else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    a_err_rdzero: assert property (rd_s ##0 pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_rd_upper: assert property (rd_s |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_pin_in_en: assert property (wr_s(12'h14C) |-> ##2 irq_pin_a_in_en == $past(pwdata[4], 2))
        else $error("pin a input enable wrong");
    a_st_follow: assert property (wr_s(12'h1B4) |-> ##2 selftest_negative == ($past(pwdata[7:0], 2) == 8'h09))
        else $error("negative self-test wrong");
    a_st_neg: assert property (selftest_negative |-> selftest_active)
        else $error("negative without active");
    a_reset_start: assert property (wr_s(12'h1F8) ##0 pwdata[7:0] == 8'hB6 && !soft_reset_busy |-> ##2 soft_reset_busy)
        else $error("soft reset not started");
    a_busy_hold: assert property ($rose(soft_reset_busy) |-> soft_reset_busy [*8])
        else $error("soft reset ended early");
    a_acq_gate: assert property (soft_reset_busy |-> ##2 !acq_enable)
        else $error("acquiring during soft reset");
    a_out_reset: assert property ($rose(presetn) |-> !acq_enable && !soft_reset_busy && !selftest_active)
        else $error("outputs not at reset");
endmodule
bind apc_regs apc_regs_assertions u_apc_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .acq_enable(acq_enable),
    .selftest_active(selftest_active), .selftest_negative(selftest_negative),
    .soft_reset_busy(soft_reset_busy), .irq_pin_a_in_en(irq_pin_a_in_en)
);

// File: sim/apc_evt_src.sv
`timescale 1ns/1ps
// Acquisition stand-in: one ready pulse in any eight clocks of run
module apc_evt_src (
    input  wire pclk,
    input  wire presetn,
    input  wire run,
    output reg  data_ready_evt
);
    reg [2:0] cnt_r; // Free sample-period counter
    // Single-cycle pulses, so each counts as one event
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r          <= 3'h0;
            data_ready_evt <= 1'b0;
        end else begin
            cnt_r          <= cnt_r + 3'h1;
            data_ready_evt <= run && (cnt_r == 3'h7);
        end
    end
endmodule

// File: sim/apc_regs_bench.sv
`timescale 1ns/1ps
module apc_regs_bench;
    localparam SRC = 20; // Short soft-reset count keeps the run brief
    reg         pclk, presetn, psel, penable, pwrite, run;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    reg  [3:0]  pstrb;
    wire [31:0] prdata;
    wire        pready, pslverr, evt, acq, st_on, st_neg, busy, a_out, a_oe, a_in, b_out, b_oe, b_in;
    reg  [7:0]  rd, ca, cb, rt, v;
    reg         er;
    integer     fails, comparisons, seed, i, n;
    apc_regs #(.SOFT_RESET_CYCLES(SRC)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_ready_evt(evt), .acq_enable(acq), .selftest_active(st_on), .selftest_negative(st_neg),
        .soft_reset_busy(busy), .irq_pin_a_out(a_out), .irq_pin_a_oe(a_oe), .irq_pin_a_in_en(a_in),
        .irq_pin_b_out(b_out), .irq_pin_b_oe(b_oe), .irq_pin_b_in_en(b_in)
    );
    apc_evt_src src (.pclk(pclk), .presetn(presetn), .run(run), .data_ready_evt(evt));
    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    // Verdict and end of run
    task results;
        begin
            $display("comparisons %0d fails %0d", comparisons, fails);
            if (fails == 0 && comparisons > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    // Counts each compare, reports a miss at once
    task chk(input [31:0] s, input [31:0] x);
        begin
            comparisons = comparisons + 1;
            if (s !== x) begin
                fails = fails + 1;
                $display("BAD %0t got %h want %h", $time, s, x);
            end
        end
    endtask
    // One APB transfer, held until pready is sampled high
    task apb(input w, input [11:0] a, input [7:0] d);
        begin
            @(posedge pclk);
            psel   <= 1'b1;
            pwrite <= w;
            paddr  <= a;
            pwdata <= {24'h0, d};
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) @(posedge pclk);
            rd = prdata[7:0];
            er = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rdc(input [11:0] a, input [7:0] x);
        begin
            apb(1'b0, a, 8'h00);
            chk(rd, x);
        end
    endtask
    // Pin {level, enable}: open drain only pulls low
    function [1:0] pin(input [7:0] c, input act);
        begin
            // A pin whose output is off rests low and undriven
            pin[1] = c[3] && (act ? c[1] : !c[1]);
            pin[0] = c[3] && (!c[2] || !pin[1]);
        end
    endfunction
    // Watchdog far beyond the expected run
    initial begin
        repeat (4000) @(posedge pclk);
        fails = fails + 1;
        results;
    end
    initial begin
        seed = 32'h8F421C7E;
        fails = 0;
        comparisons = 0;
        {presetn, psel, penable, pwrite, run, paddr, pwdata, pstrb} = {5'h00, 12'h000, 32'h0, 4'hF};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rdc(12'h14C, 8'h00);
        rdc(12'h150, 8'h00);
        rdc(12'h160, 8'h00);
        rdc(12'h1B4, 8'h00);
        rdc(12'h1F0, 8'h03);
        rdc(12'h1F4, 8'h00);
        // Unmapped place refuses, reads zero
        apb(1'b1, 12'h100, 8'h5A);
        chk(er, 1);
        apb(1'b0, 12'h100, 8'h00);
        chk({er, rd}, 9'h100);
        apb(1'b1, 12'h160, 8'hFF);
        rdc(12'h160, 8'h44);
        // Events while off must not set the flag
        run <= 1'b1;
        repeat (16) @(posedge pclk);
        run <= 1'b0;
        rdc(12'h074, 8'h00);
        apb(1'b1, 12'h1F4, 8'h04);
        apb(1'b1, 12'h1F0, 8'h00);
        repeat (2) @(posedge pclk);
        chk(acq, 1);
        // Random pin setups over all four routings
        for (i = 0; i < 8; i = i + 1) begin
            ca = 8'($random(seed)) & 8'h1E;
            cb = 8'($random(seed)) & 8'h1E;
            rt = {1'b0, i[1], 3'h0, i[0], 2'h0};
            apb(1'b1, 12'h14C, ca);
            apb(1'b1, 12'h150, cb);
            apb(1'b1, 12'h160, rt);
            rdc(12'h150, cb);
            repeat (2) @(posedge pclk);
            chk({a_in, a_out, a_oe}, {ca[4], pin(ca, 1'b0)});
            chk({b_in, b_out, b_oe}, {cb[4], pin(cb, 1'b0)});
            run <= 1'b1;
            repeat (8) @(posedge pclk);
            run <= 1'b0;
            repeat (4) @(posedge pclk);
            chk({a_out, a_oe}, pin(ca, rt[2]));
            chk({b_out, b_oe}, pin(cb, rt[6]));
            rdc(12'h074, 8'h80);
            rdc(12'h074, 8'h00);
        end
        // Self-test codes, ending switched off
        for (i = 0; i < 4; i = i + 1) begin
            v = (i == 0) ? 8'h09 : (i == 1) ? 8'h0D : (i == 2) ? 8'h05 : 8'h00;
            apb(1'b1, 12'h1B4, v);
            repeat (2) @(posedge pclk);
            chk({st_on, st_neg}, {v == 8'h09 || v == 8'h0D, v == 8'h09});
        end
        // Soft reset issued from suspend
        apb(1'b1, 12'h1F0, 8'h03);
        apb(1'b1, 12'h1F8, 8'hB6);
        // Busy is sampled at falling edges, well clear of the launching edge
        n = 0;
        @(negedge pclk);
        chk(busy, 1);
        while (busy === 1'b1) begin
            n = n + 1;
            @(negedge pclk);
        end
        chk(n, SRC);
        rdc(12'h1F0, 8'h03);
        rdc(12'h1F4, 8'h00);
        rdc(12'h14C, 8'h00);
        rdc(12'h160, 8'h00);
        results;
    end
endmodule
